// ### nand_host_pkg.sv
/*
 * constants for the nand erase/reset/status/signature host controller.
 * assumes a single asynchronous nand device on the strobe pins and an
 * ahb-lite master that reaches the controller's own registers.
 */
package nand_host_pkg;

    // ------------------------------------------------------------------
    // own register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] block_off = 8'h04;
    localparam logic [7:0] state_off = 8'h08;
    localparam logic [7:0] status_off = 8'h0c;
    localparam logic [7:0] sig_off = 8'h10;

    // ctrl register fields
    localparam int go_bit = 0;
    localparam int op_lsb = 1;
    localparam int wide_bit = 4;

    // state register fields
    localparam int busy_bit = 0;
    localparam int rb_bit = 1;
    localparam int done_bit = 2;

    // ------------------------------------------------------------------
    // device command bytes and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] cmd_erase_setup = 8'h60;
    localparam logic [7:0] cmd_erase_confirm = 8'hd0;
    localparam logic [7:0] cmd_reset = 8'hff;
    localparam logic [7:0] cmd_status = 8'h70;
    localparam logic [7:0] cmd_signature = 8'h90;
    localparam logic [7:0] sig_address = 8'h00;

    localparam int write_protect_flag = 7;
    localparam int ctrl_or_cache_ready_flag = 6;
    localparam int array_ctrl_ready_flag = 5;
    localparam int operation_fail_flag = 0;

    // block address: byte mode row bits 15:6, word mode row bits 14:5, 10 bits
    localparam int block_bits = 10;
    localparam int sig_bytes = 4;

    // ------------------------------------------------------------------
    // operations requested through ctrl
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        op_erase = 3'b000,
        op_reset = 3'b001,
        op_status = 3'b010,
        op_signature = 3'b011
    } op_t;

    // ------------------------------------------------------------------
    // strobe timing
    // ------------------------------------------------------------------
    localparam int clk_period_ps = 4000;
    localparam int strobe_time_ps = 25000;
    localparam int strobe_cycles =
        (strobe_time_ps + clk_period_ps - 1) / clk_period_ps;
    localparam int cnt_width = 8;

endpackage

// ### nand_strobe_cycle.sv
/*
 * one nand bus cycle: a write (command/address) or a read of one byte.
 * assumes the device meets its setup and hold within strobe_cycles.
 */
`timescale 1ns/10ps
module nand_strobe_cycle
    import nand_host_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // request
    input wire logic start,
    input wire logic is_read,
    input wire logic is_cmd,
    input wire logic [7:0] wr_byte,
    output logic done,
    output logic [7:0] rd_byte,
    // pins
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic re_n,
    output logic [7:0] io_out,
    output logic io_oe
);
    typedef enum logic [1:0] {
        s_idle = 2'b00,
        s_low = 2'b01,
        s_high = 2'b10
    } cyc_t;

    cyc_t state_reg;
    logic [cnt_width-1:0] cnt_reg;
    localparam logic [cnt_width-1:0] cnt_top = cnt_width'(strobe_cycles - 1);

    assign done = (state_reg == s_high) && (cnt_reg == '0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= s_idle;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                s_idle: begin
                    if (start) begin
                        state_reg <= s_low;
                        cnt_reg <= cnt_top;
                    end
                end
                s_low: begin
                    if (cnt_reg == '0) begin
                        state_reg <= s_high;
                        cnt_reg <= cnt_top;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                s_high: begin
                    if (cnt_reg == '0) begin
                        state_reg <= s_idle;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                default: state_reg <= s_idle;
            endcase
        end
    end

    // pins: latch enables held across both halves of the cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cle <= 1'b0;
            ale <= 1'b0;
            we_n <= 1'b1;
            re_n <= 1'b1;
            io_out <= 8'h00;
            io_oe <= 1'b0;
            rd_byte <= 8'h00;
        end else if (state_reg == s_idle && start) begin
            cle <= !is_read && is_cmd; // see [R23]
            ale <= !is_read && !is_cmd; // see [R23]
            we_n <= is_read;
            re_n <= !is_read;
            io_out <= wr_byte;
            io_oe <= !is_read;
        end else if (state_reg == s_low && cnt_reg == '0) begin
            // rising write strobe latches the byte
            we_n <= 1'b1; // see [R23]
            re_n <= 1'b1;
        end else if (done) begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe <= 1'b0;
        end
    end

endmodule // nand_strobe_cycle

// ### nand_erase_reset_status_id.sv
/*
 * host controller for nand block erase, reset, status read and
 * signature read, with an ahb-lite slave for its own registers.
 * assumes one device, inputs synchronous to hclk, single word transfers.
 */
// Register access over AHB-Lite and the register addresses were decided locally.
// How it works
// [R1] device erases one whole block to ones per operation
// [R2] erase is setup command, two block address cycles, confirm command
// [R3] only the ten block address bits are sent, others are not used
// [R4] device starts erase on write strobe rise of confirm
// [R5] device's internal controller erases and verifies the block
// [R6] during erase only status read and reset are issued
// [R7] at end device sets ready flag, releases ready/busy, reports fail flag
// [R8] reset command aborts any operation and clears the device interface
// [R9] cells aborted mid erase are invalid; software is told nothing is done
// [R10] device ignores reset when already reset
// [R11] after reset the host waits for ready/busy high
// [R12] status byte is taken on the low data lanes after read strobe falls
// [R13] status is current, so host polls without reissuing the command; the host here issues 70h before every status read
// [R14] device stays in status mode until another command arrives
// [R15] write protect flag one means program and erase allowed
// [R16] in cache reads the ready flag tells page availability
// [R17] outside cache reads the ready flag shows controller ready
// [R18] array controller ready flag shows controller activity
// [R19] fail flag one after failed program or erase, zero on success
// [R20] reserved status bits are ignored by the host
// [R21] signature is command 90h, address 00h, then four read cycles
// [R22] signature byte three holds chip count, cell type and features
// [R23] commands with cle high, addresses with ale high, latched on rise
// [R24] new array operation waits for ready/busy high after erase or reset
`timescale 1ns/10ps
module nand_erase_reset_status_id
    import nand_host_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // nand pins
    output logic ce_n,
    output logic cle,
    output logic ale,
    output logic we_n,
    output logic re_n,
    output logic wp_n,
    input wire logic [7:0] io_in,
    output logic [7:0] io_out,
    output logic io_oe,
    input wire logic rb
);
    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_issue = 3'b001,
        st_wait = 3'b010,
        st_busy = 3'b011,
        st_poll = 3'b100
    } seq_t;

    seq_t seq_reg;
    op_t op_reg;
    logic wide_reg;
    logic [block_bits-1:0] block_reg;
    logic [2:0] step_reg;
    logic [7:0] status_reg;
    logic [31:0] sig_reg;
    logic done_reg;

    // one strobe cycle at a time
    logic cyc_start;
    logic cyc_read;
    logic cyc_cmd;
    logic [7:0] cyc_byte;
    logic cyc_done;
    logic s_re_n;
    logic [7:0] rd_unused;

    nand_strobe_cycle u_cycle (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(cyc_start),
        .is_read(cyc_read),
        .is_cmd(cyc_cmd),
        .wr_byte(cyc_byte),
        .done(cyc_done),
        .rd_byte(rd_unused),
        .cle(cle),
        .ale(ale),
        .we_n(we_n),
        .re_n(s_re_n),
        .io_out(io_out),
        .io_oe(io_oe)
    );
    assign re_n = s_re_n;

    // ------------------------------------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // ------------------------------------------------------------------
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    logic go_pulse;
    logic bus_busy;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign bus_busy = (seq_reg != st_idle);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite && hsize == 3'b010;
            addr_reg <= haddr;
        end
    end

    // go is refused while a sequence runs
    assign go_pulse = wr_pend_reg && (addr_reg == ctrl_off) &&
                      hwdata[go_bit] && !bus_busy;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_reg <= op_erase;
            wide_reg <= 1'b0;
            block_reg <= '0;
            wp_n <= 1'b0;
        end else if (wr_pend_reg && !bus_busy) begin
            if (addr_reg == ctrl_off) begin
                op_reg <= op_t'(hwdata[op_lsb +: 3]);
                wide_reg <= hwdata[wide_bit];
                wp_n <= hwdata[8];
            end else if (addr_reg == block_off) begin
                block_reg <= hwdata[block_bits-1:0];
            end
        end else if (seq_reg == st_poll) begin
            op_reg <= op_status; // see [R7] [R14]
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        case (addr_reg)
            ctrl_off: hrdata = {23'h0, wp_n, 3'h0, wide_reg, op_reg, 1'b0};
            block_off: hrdata = {22'h0, block_reg};
            state_off: hrdata = {29'h0, done_reg, rb, bus_busy};
            // reserved bits masked to zero
            status_off: hrdata = {24'h0, status_reg & 8'he1}; // see [R20]
            sig_off: hrdata = sig_reg;
            default: hrdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // address bytes: block number placed at its row address position
    // ------------------------------------------------------------------
    function automatic logic [15:0] block_row(
        input logic [block_bits-1:0] blk, input logic wide);
        logic [15:0] row;
        row = {6'h00, blk} << (wide ? 5 : 6); // see [R3]
        return row;
    endfunction

    logic [15:0] row_addr;
    assign row_addr = block_row(block_reg, wide_reg);

    // byte for each step of each operation
    always_comb begin
        cyc_cmd = 1'b1;
        cyc_read = 1'b0;
        cyc_byte = cmd_status;
        case (op_reg)
            op_erase: begin
                case (step_reg) // see [R2]
                    3'd0: cyc_byte = cmd_erase_setup;
                    3'd1: begin cyc_cmd = 1'b0; cyc_byte = row_addr[7:0]; end
                    3'd2: begin cyc_cmd = 1'b0; cyc_byte = row_addr[15:8]; end
                    default: cyc_byte = cmd_erase_confirm; // see [R4]
                endcase
            end
            op_reset: cyc_byte = cmd_reset; // see [R8]
            op_signature: begin
                case (step_reg) // see [R21]
                    3'd0: cyc_byte = cmd_signature;
                    3'd1: begin cyc_cmd = 1'b0; cyc_byte = sig_address; end
                    default: cyc_read = 1'b1;
                endcase
            end
            default: begin
                if (step_reg != 3'd0) begin
                    cyc_read = 1'b1;
                end
            end
        endcase
    end

    function automatic logic [2:0] last_step(input op_t op);
        case (op)
            op_erase: last_step = 3'd3;
            op_reset: last_step = 3'd0;
            op_signature: last_step = 3'd5;
            default: last_step = 3'd1;
        endcase
    endfunction

    // read data sampled at the end of the low half of re_n
    logic sample;
    assign sample = cyc_read && !s_re_n && seq_reg == st_wait;
    logic s_re_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_re_q <= 1'b1;
        end else begin
            s_re_q <= s_re_n;
        end
    end

    assign cyc_start = (seq_reg == st_issue);
    assign ce_n = (seq_reg == st_idle);

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_reg <= st_idle;
            step_reg <= 3'd0;
            done_reg <= 1'b0;
        end else begin
            case (seq_reg)
                st_idle: begin
                    if (go_pulse) begin
                        seq_reg <= st_issue;
                        step_reg <= 3'd0;
                        done_reg <= 1'b0; // see [R9]
                    end
                end
                st_issue: seq_reg <= st_wait;
                st_wait: begin
                    if (cyc_done) begin
                        if (step_reg != last_step(op_reg)) begin
                            step_reg <= step_reg + 3'd1;
                            seq_reg <= st_issue;
                        end else if (op_reg == op_erase ||
                                     op_reg == op_reset) begin
                            seq_reg <= st_busy; // see [R6]
                        end else begin
                            seq_reg <= st_idle;
                            done_reg <= 1'b1;
                        end
                    end
                end
                st_busy: begin
                    // rb falls within the device's busy delay; wait on rb
                    if (rb) begin // see [R24] [R11]
                        seq_reg <= (op_reg == op_erase) ? st_poll : st_idle;
                        done_reg <= (op_reg != op_erase);
                    end
                end
                st_poll: begin
                    // fetch pass/fail once ready, status command then read
                    step_reg <= 3'd0;
                    seq_reg <= st_issue;
                end
                default: seq_reg <= st_idle;
            endcase
        end
    end

    // captured bytes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= 8'h00;
            sig_reg <= 32'h0000_0000;
        end else if (sample && s_re_q == 1'b0 && cyc_done == 1'b0) begin
            if (op_reg == op_signature) begin
                // bytes in read order: maker, device, config, geometry
                sig_reg[(step_reg - 3'd2) * 8 +: 8] <= io_in; // see [R22]
            end else begin
                // flags [R15] [R17] [R18] [R19] kept as read
                status_reg <= io_in; // see [R12] [R13] [R16]
            end
        end
    end
endmodule // nand_erase_reset_status_id

// ### nand_host_props.sv
/*
 * checker for the nand host controller, bound to its top module.
 * assumes a single hclk domain with hresetn as asynchronous reset.
 */
`timescale 1ns/10ps
module nand_host_props
    import nand_host_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // nand pins
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic [7:0] io_out,
    input wire logic io_oe,
    input wire logic rb
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus answer not zero wait okay");
    property p_latch_excl;
        !(cle && ale);
    endproperty
    a_latch_excl: assert property (p_latch_excl)
        else $error("command and address latch both high");
    property p_strobe_excl;
        we_n || re_n;
    endproperty
    a_strobe_excl: assert property (p_strobe_excl)
        else $error("write and read strobes both low");
    property p_write_drives;
        !we_n |-> io_oe;
    endproperty
    a_write_drives: assert property (p_write_drives)
        else $error("write strobe low with data lanes released");
    property p_read_release;
        !re_n |-> !io_oe;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("host drives lanes during a read strobe");
    property p_idle_quiet;
        ce_n |-> we_n && re_n;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("strobe pulsed while chip deselected");
    property p_we_width;
        $fell(we_n) |-> (!we_n) [*7];
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write strobe low for under seven cycles");
    // only status and reset may reach a busy device
    property p_busy_cmds;
        !we_n && cle && !rb |-> io_out == cmd_status || io_out == cmd_reset;
    endproperty
    a_busy_cmds: assert property (p_busy_cmds)
        else $error("array command sent while device busy");

    c_erase: cover property (!we_n && cle && io_out == cmd_erase_setup);
    c_reset: cover property (!we_n && cle && io_out == cmd_reset);
    c_sig: cover property (!we_n && ale && io_out == sig_address);
    c_read: cover property ($fell(re_n));
endmodule // nand_host_props

// ### nand_dev_model.sv
/*
 * behavioural nand device: erase, reset, status and signature only.
 * assumes the host strobes pins as a real controller would; no clock.
 */
`timescale 1ns/10ps
module nand_dev_model
    import nand_host_pkg::*;
#(
    parameter int erase_ns = 2000,
    parameter int reset_ns = 400,
    parameter logic [9:0] bad_blk = 10'h3ff,
    parameter logic [7:0] maker_code = 8'h3c, // arbitrary value
    parameter logic [7:0] dev_code = 8'h5a, // arbitrary value
    parameter logic [7:0] cfg_byte = 8'h44,
    parameter logic [7:0] geo_byte = 8'h11
)
(
    // host pins
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic wp_n,
    input wire logic [7:0] io_out,
    input wire logic io_oe,
    input wire logic wide,
    // device pins
    output logic [7:0] io_in,
    output logic rb
);
    logic [7:0] cmd_reg, last_reg, out_byte;
    logic [15:0] row;
    logic [9:0] last_blk;
    logic fail_reg, in_reset, seq_err, busy;
    int n_adr, sig_idx, wait_ns;
    event go_ev;

    initial begin
        rb = 1'b1;
        busy = 1'b0;
        fail_reg = 1'b0;
        in_reset = 1'b1;
        seq_err = 1'b0;
        n_adr = 0;
        sig_idx = 0;
        cmd_reg = 8'h00;
        last_reg = 8'h00;
        row = 16'h0000;
        last_blk = 10'h000;
    end

    // ------------------------------------------------------------------
    // latching on the write strobe rise
    // ------------------------------------------------------------------
    always @(posedge we_n) if (!ce_n) begin
        if (!io_oe) seq_err = 1'b1;
        if (cle && busy && io_out != cmd_status && io_out != cmd_reset) begin
            seq_err = 1'b1;
        end else if (cle) begin
            if (io_out == cmd_erase_confirm) begin
                if (cmd_reg != cmd_erase_setup || n_adr != 2) seq_err = 1'b1;
                else if (wp_n) begin
                    last_blk = wide ? row[14:5] : row[15:6];
                    fail_reg = last_blk == bad_blk;
                    in_reset = 1'b0;
                    wait_ns = erase_ns;
                    -> go_ev;
                end
            end else if (io_out == cmd_reset && !in_reset) begin
                fail_reg = 1'b0;
                in_reset = 1'b1;
                wait_ns = reset_ns;
                -> go_ev;
            end
            cmd_reg = io_out;
            n_adr = 0;
            sig_idx = 0;
        end else if (ale) begin
            if (cmd_reg == cmd_signature && io_out != sig_address) begin
                seq_err = 1'b1;
            end
            row = {io_out, row[15:8]};
            n_adr++;
        end
    end

    always begin
        @(go_ev);
        busy = 1'b1;
        rb = 1'b0;
        #(wait_ns);
        busy = 1'b0;
        rb = 1'b1;
    end

    // ------------------------------------------------------------------
    // read side
    // ------------------------------------------------------------------
    // reserved status bits are deliberately nonzero; cache reads unmodelled
    always_comb begin
        if (cmd_reg == cmd_status) begin
            out_byte[7:6] = {wp_n, !busy};
            out_byte[5:0] = {!busy, 4'b1010, fail_reg};
        end else begin
            case (sig_idx)
                0: out_byte = maker_code;
                1: out_byte = dev_code;
                2: out_byte = cfg_byte;
                3: out_byte = geo_byte;
                default: out_byte = ~geo_byte;
            endcase
        end
    end
    // an undriven bus shows the inverse of its last value, never a hold
    assign io_in = (!ce_n && !re_n) ? out_byte : ~last_reg;
    always @(posedge re_n) if (!ce_n) begin
        last_reg = out_byte;
        if (cmd_reg == cmd_signature) sig_idx++;
    end
endmodule // nand_dev_model

// ### tb_nand_erase_reset_status_id.sv
/*
 * testbench: ahb-lite register tasks drive the controller against
 * the nand device model; assumes zero wait state okay answers.
 */
`timescale 1ns/10ps
module tb_nand_erase_reset_status_id;
    import nand_host_pkg::*;
    localparam logic [31:0] sig_word = 32'h11445a3c;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, wide;
    logic [7:0] haddr, io_in, io_out;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata;
    logic ce_n, cle, ale, we_n, re_n, wp_n, io_oe, rb;
    int n_mismatch, compares;

    assign hready = hreadyout;
    nand_erase_reset_status_id nand_erase_reset_status_id_inst(
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .re_n(re_n), .wp_n(wp_n), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe), .rb(rb));
    nand_dev_model nand_dev_model_inst(
        .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
        .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe), .wide(wide),
        .io_in(io_in), .rb(rb));

    initial hclk = 1'b0;
    always #2 hclk = ~hclk;

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic cmp(string name, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] r);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rd_cmp(string name, logic [7:0] a, logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        cmp(name, e, r);
    endtask
    function automatic logic [31:0] ctl(logic [2:0] op, logic w, logic p);
        return {23'h0, p, 3'h0, w, op, 1'b1};
    endfunction
    // starts an operation and polls the done flag under a bound
    task automatic run_op(logic [31:0] c, logic [9:0] refused_blk);
        logic [31:0] s;
        wide = c[wide_bit];
        wr_reg(ctrl_off, c);
        wr_reg(block_off, {22'h0, refused_blk});
        for (int i = 0; i < 3000; i++) begin
            ahb(1'b0, state_off, 32'h0, s);
            if (s[done_bit] === 1'b1) break;
        end
        cmp("done", 32'h1, {31'h0, s[done_bit]});
    endtask
    task automatic close_out;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        compares = 0;
        hsel = 1'b1;
        haddr = 8'h00;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        wide = 1'b0;
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_cmp("state", state_off, 32'h2);
        rd_cmp("unmapped", 8'h14, 32'h0);
        cmp("wp_pin", 32'h0, {31'h0, wp_n});
        $display("test reset_values done");
        run_op(ctl(op_status, 1'b0, 1'b0), 10'h0);
        rd_cmp("status", status_off, 32'h60);
        $display("test protected_status done");
        wr_reg(block_off, 32'h201);
        run_op(ctl(op_erase, 1'b0, 1'b1), 10'h003);
        rd_cmp("status", status_off, 32'he0);
        cmp("block", 32'h201, nand_dev_model_inst.last_blk);
        $display("test erase_x8 done");
        wr_reg(block_off, 32'h3ff);
        run_op(ctl(op_erase, 1'b1, 1'b1), 10'h001);
        rd_cmp("status", status_off, 32'he1);
        cmp("block", 32'h3ff, nand_dev_model_inst.last_blk);
        $display("test erase_x16_fail done");
        run_op(ctl(op_reset, 1'b0, 1'b1), 10'h0);
        run_op(ctl(op_status, 1'b0, 1'b1), 10'h0);
        rd_cmp("status", status_off, 32'he0);
        $display("test reset done");
        run_op(ctl(op_signature, 1'b0, 1'b1), 10'h0);
        rd_cmp("signature", sig_off, sig_word);
        cmp("sequence", 32'h0, 32'(nand_dev_model_inst.seq_err));
        $display("test signature done");
        close_out();
    end

    initial begin
        #300000;
        n_mismatch++;
        close_out();
    end
endmodule // tb_nand_erase_reset_status_id

bind nand_erase_reset_status_id nand_host_props nand_host_props_inst(
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .io_out(io_out), .io_oe(io_oe), .rb(rb));
